//--- rtl/urhps_pkg.sv
// Constants for the root hub power and status register block
package urhps_pkg;

	// Register byte offsets
	localparam logic [7:0] URHPS_ADDR_PORT_CFG = 8'h4c;
	localparam logic [7:0] URHPS_ADDR_GLOBAL_STATUS = 8'h50;

	// Implemented downstream ports, numbered 1..URHPS_NUM_PORTS
	localparam int URHPS_NUM_PORTS = 5;
	localparam int URHPS_FIELD_W = 16;

	// Port config field positions
	localparam int URHPS_POWER_SELECT_LSB = 16;
	localparam int URHPS_DEVICE_FLAGS_LSB = 0;

	// Global status bit positions
	localparam int URHPS_WAKE_CLR_BIT = 31;
	localparam int URHPS_OVERLOAD_CHG_BIT = 17;
	localparam int URHPS_SUPPLY_CHG_BIT = 16;
	localparam int URHPS_POWER_ON_BIT = 16;
	localparam int URHPS_WAKE_EN_BIT = 15;
	localparam int URHPS_OVERLOAD_BIT = 1;
	localparam int URHPS_SUPPLY_STATE_BIT = 0;
	localparam int URHPS_POWER_OFF_BIT = 0;

	// Reset values
	localparam logic [31:0] URHPS_PORT_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] URHPS_GLOBAL_STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] URHPS_RDATA_IDLE = 32'h0000_0000;

endpackage : urhps_pkg

//--- rtl/urhps_power_gate.sv
// Spreads global power commands onto the ports they may reach
`timescale 1ns/1ps
module urhps_power_gate
	import urhps_pkg::*;
(
	// Command bundle
	urhps_pwr_if.gate pwr
);

	genvar i;
	generate
		for (i = 0; i < URHPS_FIELD_W; i++) begin : g_port
			if (i >= 1 && i <= URHPS_NUM_PORTS) begin : g_real
				// Mask counts only in individual mode
				logic reach;
				assign reach = ~pwr.indiv_mode | ~pwr.mask[i];
				assign pwr.port_on[i] = pwr.glob_on & reach;
				assign pwr.port_off[i] = pwr.glob_off & reach;
			end else begin : g_none
				// Bit 0 and absent ports never get a command
				assign pwr.port_on[i] = 1'b0;
				assign pwr.port_off[i] = 1'b0;
			end
		end
	endgenerate

endmodule : urhps_power_gate

//--- rtl/urhps_pwr_if.sv
// Global power command bundle between register logic and port gating
`timescale 1ns/1ps
interface urhps_pwr_if;
	import urhps_pkg::*;
	logic glob_on;
	logic glob_off;
	logic indiv_mode;
	logic [URHPS_FIELD_W-1:0] mask;
	logic [URHPS_FIELD_W-1:0] port_on;
	logic [URHPS_FIELD_W-1:0] port_off;
	modport ctrl (output glob_on, output glob_off, output indiv_mode, output mask,
		input port_on, input port_off);
	modport gate (input glob_on, input glob_off, input indiv_mode, input mask,
		output port_on, output port_off);
endinterface : urhps_pwr_if

//--- rtl/urhps_regs.sv
// Root hub port config and global status registers with power commands
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module urhps_regs
	import urhps_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,

	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,

	// Modes held by the companion descriptor register
	input wire logic individual_switching_select,
	input wire logic per_port_overload_mode,

	// Hub side events
	input wire logic global_overload_in,
	input wire logic [URHPS_NUM_PORTS:1] attach_change_flag,
	input wire logic controller_sleep_state,

	// Port power command pulses
	output logic [URHPS_NUM_PORTS:1] port_power_on_cmd,
	output logic [URHPS_NUM_PORTS:1] port_power_off_cmd,

	// Wake outputs
	output logic connect_wake_enable,
	output logic controller_wake_state,
	output logic wake_seen_interrupt,

	// Per-port configuration levels
	output logic [URHPS_NUM_PORTS:1] per_port_power_select,
	output logic [URHPS_NUM_PORTS:1] fixed_device_flags
);

	typedef struct packed {
		logic [URHPS_FIELD_W-1:0] power_select;
		logic [URHPS_FIELD_W-1:0] device_flags;
		logic wake_en;
		logic overload;
		logic overload_chg;
		logic [URHPS_NUM_PORTS:1] attach_prev;
		logic [31:0] rdata;
		logic [URHPS_NUM_PORTS:1] pwr_on;
		logic [URHPS_NUM_PORTS:1] pwr_off;
		logic resume;
		logic wake_irq;
	} urhps_state_t;

	urhps_state_t st_q;
	urhps_state_t st_d;

	urhps_pwr_if pwr ();

	// Decode
	logic cfg_sel;
	logic sts_sel;
	logic cfg_wr;
	logic sts_wr;
	logic on_req;
	logic off_req;
	logic overload_now;
	logic attach_edge;
	logic resume_ev;
	logic [31:0] cfg_view;
	logic [31:0] sts_view;

	assign cfg_sel = (reg_addr == URHPS_ADDR_PORT_CFG);
	assign sts_sel = (reg_addr == URHPS_ADDR_GLOBAL_STATUS);
	assign cfg_wr = reg_wr & cfg_sel;
	assign sts_wr = reg_wr & sts_sel;

	// Off wins over on when both are written together, leaving the reachable ports unpowered
	assign on_req = sts_wr & reg_wdata[URHPS_POWER_ON_BIT] & ~reg_wdata[URHPS_POWER_OFF_BIT];
	assign off_req = sts_wr & reg_wdata[URHPS_POWER_OFF_BIT];

	assign pwr.glob_on = on_req;
	assign pwr.glob_off = off_req;
	assign pwr.indiv_mode = individual_switching_select;
	assign pwr.mask = st_q.power_select;

	urhps_power_gate u_gate (
		.pwr (pwr.gate)
	);

	// Global overload is hidden entirely when reporting is per port
	assign overload_now = global_overload_in & ~per_port_overload_mode;

	// Inputs are synchronous, so a plain edge detect is safe here
	assign attach_edge = |(attach_change_flag & ~st_q.attach_prev);
	assign resume_ev = attach_edge & st_q.wake_en & controller_sleep_state;

	// Read views
	always_comb begin
		cfg_view = {st_q.power_select, st_q.device_flags};
		sts_view = URHPS_GLOBAL_STATUS_RST;
		sts_view[URHPS_OVERLOAD_CHG_BIT] = st_q.overload_chg;
		sts_view[URHPS_SUPPLY_CHG_BIT] = 1'b0;
		sts_view[URHPS_WAKE_EN_BIT] = st_q.wake_en;
		sts_view[URHPS_OVERLOAD_BIT] = st_q.overload;
		sts_view[URHPS_SUPPLY_STATE_BIT] = 1'b0;
	end

	always_comb begin
		st_d = st_q;

		// Config register stores every bit, even for absent ports
		if (cfg_wr) begin
			st_d.power_select = reg_wdata[URHPS_POWER_SELECT_LSB +: URHPS_FIELD_W];
			st_d.device_flags = reg_wdata[URHPS_DEVICE_FLAGS_LSB +: URHPS_FIELD_W];
		end

		// Wake enable: clear wins if both command bits are written at once
		if (sts_wr && reg_wdata[URHPS_WAKE_CLR_BIT]) begin
			st_d.wake_en = 1'b0;
		end else if (sts_wr && reg_wdata[URHPS_WAKE_EN_BIT]) begin
			st_d.wake_en = 1'b1;
		end

		// Overload tracking; a change in the same cycle beats the clear
		st_d.overload = overload_now;
		if (overload_now != st_q.overload) begin
			st_d.overload_chg = 1'b1;
		end else if (sts_wr && reg_wdata[URHPS_OVERLOAD_CHG_BIT]) begin
			st_d.overload_chg = 1'b0;
		end

		// Power command pulses last one cycle
		st_d.pwr_on = pwr.port_on[URHPS_NUM_PORTS:1];
		st_d.pwr_off = pwr.port_off[URHPS_NUM_PORTS:1];

		// Wake event pulses
		st_d.attach_prev = attach_change_flag;
		st_d.resume = resume_ev;
		st_d.wake_irq = resume_ev;

		// Read data stand only in the cycle after the strobe
		if (reg_rd && cfg_sel) begin
			st_d.rdata = cfg_view;
		end else if (reg_rd && sts_sel) begin
			st_d.rdata = sts_view;
		end else begin
			st_d.rdata = URHPS_RDATA_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q.power_select <= URHPS_PORT_CFG_RST[URHPS_POWER_SELECT_LSB +: URHPS_FIELD_W];
			st_q.device_flags <= URHPS_PORT_CFG_RST[URHPS_DEVICE_FLAGS_LSB +: URHPS_FIELD_W];
			st_q.wake_en <= URHPS_GLOBAL_STATUS_RST[URHPS_WAKE_EN_BIT];
			st_q.overload <= URHPS_GLOBAL_STATUS_RST[URHPS_OVERLOAD_BIT];
			st_q.overload_chg <= URHPS_GLOBAL_STATUS_RST[URHPS_OVERLOAD_CHG_BIT];
			st_q.attach_prev <= '0;
			st_q.rdata <= URHPS_RDATA_IDLE;
			st_q.pwr_on <= '0;
			st_q.pwr_off <= '0;
			st_q.resume <= 1'b0;
			st_q.wake_irq <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = st_q.rdata;
	assign port_power_on_cmd = st_q.pwr_on;
	assign port_power_off_cmd = st_q.pwr_off;
	assign connect_wake_enable = st_q.wake_en;
	assign controller_wake_state = st_q.resume;
	assign wake_seen_interrupt = st_q.wake_irq;
	assign per_port_power_select = st_q.power_select[URHPS_NUM_PORTS:1];
	assign fixed_device_flags = st_q.device_flags[URHPS_NUM_PORTS:1];

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_mask_blocks_on: assert property (
		on_req && individual_switching_select
		|=> (port_power_on_cmd & $past(st_q.power_select[URHPS_NUM_PORTS:1])) == '0)
		else $error("Global power on reached a masked port");

	a_clear_mask_on: assert property (
		on_req && individual_switching_select
		|=> port_power_on_cmd == ~$past(st_q.power_select[URHPS_NUM_PORTS:1]))
		else $error("Global power on missed an unmasked port");

	a_global_on_all: assert property (
		on_req && !individual_switching_select
		|=> port_power_on_cmd == '1 ##1 port_power_on_cmd == '0 || $past(on_req))
		else $error("Global mode power on did not reach all ports for one cycle");

	a_global_off_all: assert property (
		off_req && !individual_switching_select |=> port_power_off_cmd == '1)
		else $error("Global mode power off did not reach all ports");

	a_indiv_off_mask: assert property (
		off_req && individual_switching_select
		|=> port_power_off_cmd == ~$past(st_q.power_select[URHPS_NUM_PORTS:1]))
		else $error("Individual mode power off went to the wrong ports");

	a_mask_ignored_global: assert property (
		(sts_wr && !individual_switching_select && st_q.power_select[1]
		&& reg_wdata[URHPS_POWER_OFF_BIT]) |=> port_power_off_cmd[1])
		else $error("Mask obeyed in global switching mode");

	a_no_cmd_idle: assert property (
		!on_req && !off_req |=> port_power_on_cmd == '0 && port_power_off_cmd == '0)
		else $error("Power command pulse without a write");

	a_wake_clear: assert property (
		sts_wr && reg_wdata[URHPS_WAKE_CLR_BIT] |=> !connect_wake_enable)
		else $error("Wake enable not cleared");

	a_wake_set: assert property (
		sts_wr && reg_wdata[URHPS_WAKE_EN_BIT] && !reg_wdata[URHPS_WAKE_CLR_BIT]
		|=> connect_wake_enable)
		else $error("Wake enable not set");

	a_wake_zero_hold: assert property (
		!(sts_wr && (reg_wdata[URHPS_WAKE_CLR_BIT] || reg_wdata[URHPS_WAKE_EN_BIT]))
		|=> $stable(connect_wake_enable))
		else $error("Wake enable moved without a command");

	a_overload_chg_set: assert property (
		$changed(st_q.overload) |-> st_q.overload_chg)
		else $error("Overload change flag missed a change");

	a_overload_chg_clr: assert property (
		sts_wr && reg_wdata[URHPS_OVERLOAD_CHG_BIT] && overload_now == st_q.overload
		|=> !st_q.overload_chg)
		else $error("Overload change flag not cleared by write of one");

	a_overload_chg_hold: assert property (
		st_q.overload_chg && !(sts_wr && reg_wdata[URHPS_OVERLOAD_CHG_BIT])
		|=> st_q.overload_chg)
		else $error("Overload change flag lost without a clear");

	a_overload_perport: assert property (
		per_port_overload_mode |=> !st_q.overload)
		else $error("Global overload shown under per-port reporting");

	a_supply_bits_zero: assert property (
		$past(reg_rd) && $past(sts_sel)
		|-> !reg_rdata[URHPS_SUPPLY_CHG_BIT] && !reg_rdata[URHPS_SUPPLY_STATE_BIT])
		else $error("Local supply bits read nonzero");

	a_cfg_readback: assert property (
		reg_rd && cfg_sel && !reg_wr
		|=> reg_rdata == {$past(st_q.power_select), $past(st_q.device_flags)})
		else $error("Port config read did not return stored value");

	a_rdata_one_cycle: assert property (
		!reg_rd |=> reg_rdata == URHPS_RDATA_IDLE)
		else $error("Read data outside the answer cycle");

	a_resume_event: assert property (
		resume_ev |=> controller_wake_state && wake_seen_interrupt ##1 !wake_seen_interrupt
		|| $past(resume_ev))
		else $error("Resume event not raised for one cycle");

	a_no_wake_disabled: assert property (
		!st_q.wake_en |=> !controller_wake_state)
		else $error("Resume raised with wake disabled");

	a_cfg_store: assert property (
		cfg_wr |=> per_port_power_select == $past(reg_wdata[URHPS_POWER_SELECT_LSB + 1 +: URHPS_NUM_PORTS])
		&& fixed_device_flags == $past(reg_wdata[URHPS_DEVICE_FLAGS_LSB + 1 +: URHPS_NUM_PORTS]))
		else $error("Port config write did not reach the level outputs");

	a_cfg_hold: assert property (
		!cfg_wr |=> $stable(st_q.power_select) && $stable(st_q.device_flags))
		else $error("Port config moved without a write");

	a_reserved_port_idle: assert property (
		!pwr.port_on[0] && !pwr.port_off[0])
		else $error("Reserved field bit carried a power command");

	a_absent_ports_idle: assert property (
		pwr.port_on[URHPS_FIELD_W-1:URHPS_NUM_PORTS+1] == '0
		&& pwr.port_off[URHPS_FIELD_W-1:URHPS_NUM_PORTS+1] == '0)
		else $error("Absent port carried a power command");

	a_on_off_excl: assert property (
		(port_power_on_cmd & port_power_off_cmd) == '0)
		else $error("Power on and off pulsed together");

	a_off_beats_on: assert property (
		off_req |=> port_power_on_cmd == '0)
		else $error("Power on pulsed beside a power off write");

	a_reset_clear: assert property (
		$fell(rst) |-> reg_rdata == URHPS_RDATA_IDLE && !connect_wake_enable
		&& st_q.power_select == '0 && st_q.device_flags == '0 && !st_q.overload_chg)
		else $error("Registers not zero after reset");

	a_status_reserved: assert property (
		$past(reg_rd) && $past(sts_sel)
		|-> reg_rdata[URHPS_WAKE_CLR_BIT-1:URHPS_OVERLOAD_CHG_BIT+1] == '0 && !reg_rdata[URHPS_WAKE_CLR_BIT]
		&& reg_rdata[URHPS_WAKE_EN_BIT-1:URHPS_OVERLOAD_BIT+1] == '0)
		else $error("Reserved status bits read nonzero");

	a_overload_track: assert property (
		!$past(rst) |-> st_q.overload == $past(overload_now))
		else $error("Overload bit does not follow the reported condition");

	a_irq_needs_event: assert property (
		wake_seen_interrupt |-> $past(controller_sleep_state) && $past(attach_edge)
		&& $past(st_q.wake_en))
		else $error("Resume interrupt without an enabled attach event while asleep");

	a_irq_with_resume: assert property (
		wake_seen_interrupt == controller_wake_state)
		else $error("Resume request and interrupt disagree");

endmodule : urhps_regs

//--- tb/test_usb_root_hub_power_status.sv
// Self-checking bench for the root hub port config and global status registers
`timescale 1ns/1ps
module test_usb_root_hub_power_status
	import urhps_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic individual_switching_select = 1'b0;
	logic per_port_overload_mode = 1'b0;
	logic global_overload_in = 1'b0;
	logic [URHPS_NUM_PORTS:1] attach_change_flag = 5'h00;
	logic controller_sleep_state = 1'b0;
	logic [URHPS_NUM_PORTS:1] port_power_on_cmd, port_power_off_cmd;
	logic connect_wake_enable, controller_wake_state, wake_seen_interrupt;
	logic [URHPS_NUM_PORTS:1] per_port_power_select, fixed_device_flags;
	logic [31:0] rd_q[$];
	logic [9:0] pw_q[$];
	logic [1:0] wk_q[$];
	logic rd_pend = 1'b0;
	int bad_count = 0;
	int tests_run = 0;

	always #12.5 clk_sys = ~clk_sys;

	urhps_regs DUT (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .individual_switching_select(individual_switching_select),
		.per_port_overload_mode(per_port_overload_mode), .global_overload_in(global_overload_in),
		.attach_change_flag(attach_change_flag), .controller_sleep_state(controller_sleep_state),
		.port_power_on_cmd(port_power_on_cmd), .port_power_off_cmd(port_power_off_cmd),
		.connect_wake_enable(connect_wake_enable), .controller_wake_state(controller_wake_state),
		.wake_seen_interrupt(wake_seen_interrupt), .per_port_power_select(per_port_power_select),
		.fixed_device_flags(fixed_device_flags)
	);

	task chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_val

	task chk_pulse(input string name, input logic [9:0] exp, input logic [9:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_pulse

	task wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		rd_q.push_back(exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask : rd

	// One-cycle attach edge on a random port, then let any pulse pass
	task automatic attach;
		@(posedge clk_sys);
		attach_change_flag <= 5'h01 << ($urandom() % 5);
		@(posedge clk_sys);
		attach_change_flag <= 5'h00;
		repeat (3) @(posedge clk_sys);
	endtask : attach

	// Results are taken at the falling edge, well clear of input changes
	always @(posedge clk_sys) rd_pend <= reg_rd;
	always @(negedge clk_sys) begin
		if (rd_pend) begin
			chk_val("reg_rdata", rd_q.size() ? rd_q.pop_front() : 32'hdead_beef, reg_rdata);
		end else if (!rst) begin
			chk_val("idle rdata", 32'h0, reg_rdata);
		end
		if ((port_power_on_cmd | port_power_off_cmd) !== 5'h00) begin
			chk_pulse("power pulse", pw_q.size() ? pw_q.pop_front() : 10'h3ff, {port_power_on_cmd, port_power_off_cmd});
		end
		if ((controller_wake_state | wake_seen_interrupt) !== 1'b0) begin
			chk_pulse("wake pulse", wk_q.size() ? {8'h00, wk_q.pop_front()} : 10'h000,
				{8'h00, controller_wake_state, wake_seen_interrupt});
		end
	end

	initial begin
		#(25ns * 20000);
		bad_count++;
		$display("ERROR watchdog expected finish seen hang");
		wrap_up();
	end

	initial begin
		logic [31:0] cfg;
		logic [4:0] m;
		void'($urandom(32'h0f8e7682));
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(URHPS_ADDR_PORT_CFG, 32'h0);
		rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0);
		rd(8'h48, 32'h0);
		$display("test reset done");
		repeat (4) begin
			cfg = $urandom();
			wr(URHPS_ADDR_PORT_CFG, cfg);
			wr(8'h54, ~cfg);
			rd(URHPS_ADDR_PORT_CFG, cfg);
			@(negedge clk_sys);
			chk_val("power select", {27'h0, cfg[21:17]}, {27'h0, per_port_power_select});
			chk_val("device flags", {27'h0, cfg[5:1]}, {27'h0, fixed_device_flags});
		end
		$display("test config done");
		for (int mode = 0; mode < 2; mode++) begin
			individual_switching_select <= mode[0];
			cfg = $urandom() & 32'hffeb_ffff | 32'h0002_0000;
			wr(URHPS_ADDR_PORT_CFG, cfg);
			m = mode[0] ? ~cfg[21:17] : 5'h1f;
			pw_q.push_back({m, 5'h00});
			wr(URHPS_ADDR_GLOBAL_STATUS, 32'h0001_0000);
			pw_q.push_back({5'h00, m});
			wr(URHPS_ADDR_GLOBAL_STATUS, 32'h0000_0001);
			pw_q.push_back({5'h00, m});
			wr(URHPS_ADDR_GLOBAL_STATUS, 32'h0001_0001);
			rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0);
		end
		$display("test power done");
		controller_sleep_state <= 1'b1;
		attach();
		wr(URHPS_ADDR_GLOBAL_STATUS, 32'h0000_8000);
		rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0000_8000);
		@(negedge clk_sys);
		chk_val("wake enable", 32'h1, {31'h0, connect_wake_enable});
		wk_q.push_back(2'b11);
		attach();
		controller_sleep_state <= 1'b0;
		attach();
		wr(URHPS_ADDR_GLOBAL_STATUS, 32'h8000_8000);
		rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0);
		@(negedge clk_sys);
		chk_val("wake enable", 32'h0, {31'h0, connect_wake_enable});
		$display("test wake done");
		global_overload_in <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0002_0002);
		wr(URHPS_ADDR_GLOBAL_STATUS, 32'h0);
		rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0002_0002);
		wr(URHPS_ADDR_GLOBAL_STATUS, 32'h0002_0000);
		rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0000_0002);
		per_port_overload_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(URHPS_ADDR_GLOBAL_STATUS, 32'h0002_0000);
		$display("test overload done");
		repeat (4) @(posedge clk_sys);
		if (rd_q.size() + pw_q.size() + wk_q.size() != 0) begin
			bad_count++;
			$display("ERROR missing results expected 0 seen %0d", rd_q.size() + pw_q.size() + wk_q.size());
		end
		wrap_up();
	end
endmodule : test_usb_root_hub_power_status
